// ### logic/regulator_protection_interrupts.sv
`timescale 1ns/10ps
// Summary of operation
// [R1] Current limit held 20us sets flag
// [R2] Live current-limit status bit per core
// [R3] Three-bit peak current limit per core
// [R4] Short at 1ms after enable disables core
// [R5] Overload for 1ms disables core
// [R6] Short/overload sets flags, clears running, interrupts
// [R7] Clearing short flag retries start-up if enabled
// [R8] Protection disable: switches off, optional discharge
// [R9] Selectable warning threshold sets warning flag
// [R10] Warning status readable, write-one clears flag
// [R11] Overtemperature disables all, flags, standby
// [R12] Shutdown flag clear ignored while hot
// [R13] Enabling blocked while hot or flag pending
// [R14] Undervoltage: disable, discharge, shutdown, then standby
// [R15] Passing shutdown sets reset-occurred flag
// [R16] Host clears reset flag by writing one
// [R17] Detector and temperature inputs debounced by clocked counters
// [R18] 20us for temperature/ilim/pg, 1ms overload
// [R19] Enable pins only synchronized, no filter
// [R20] Power-good sets maskable per-core flag
// [R21] Interrupt held while any unmasked flag pending
// [R22] Interrupt is OR of unmasked flags
module regulator_protection_interrupts
    import regprot_pkg::*;
#(
    parameter int CORES = NUM_CORES,
    parameter int FAST_CYC = FAST_DEBOUNCE_CYC,
    parameter int SLOW_CYC = SLOW_DEBOUNCE_CYC,
    parameter int WINDOW_CYC = SHORT_WINDOW_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_reset_in_n,
    input wire logic analog_supply_rail,
    input wire logic sw_reset,
    input wire logic [CORES-1:0] core_enable_pin,
    input wire logic [CORES-1:0] core_enable_reg,
    input wire logic [CORES-1:0] enable_pin_ctrl,
    input wire regprot_pkg::core_detect_t [CORES-1:0] core_detect,
    input wire logic temp_warn_low,
    input wire logic temp_warn_high,
    input wire logic temp_shutdown,
    input wire logic thermal_warning_threshold_sel,
    input wire logic [CORES*ILIM_W-1:0] peak_current_limit_sel,
    input wire logic [CORES-1:0] discharge_pulldown_enable,
    input wire logic [CORES-1:0] core_current_limit_mask,
    input wire logic [CORES-1:0] core_power_good_mask,
    input wire logic thermal_warning_mask,
    input wire logic reset_flag_mask,
    input wire regprot_pkg::core_flags_t [CORES-1:0] core_flag_clear,
    input wire logic thermal_warning_clear,
    input wire logic thermal_shutdown_clear,
    input wire logic reset_flag_clear,
    output regprot_pkg::core_flags_t [CORES-1:0] core_flags,
    output logic [CORES-1:0] core_summary_flag,
    output logic [CORES-1:0] core_current_limit_state,
    output logic [CORES-1:0] core_power_good_state,
    output logic [CORES-1:0] core_running_state,
    output logic [CORES*ILIM_W-1:0] core_ilim_setting,
    output logic [CORES-1:0] core_switch_enable,
    output logic [CORES-1:0] core_discharge_on,
    output logic thermal_warning_flag,
    output logic thermal_warning_state,
    output logic thermal_shutdown_flag,
    output logic thermal_shutdown_state,
    output logic reset_flag,
    output regprot_pkg::dev_state_t device_state,
    output logic irq_out_n
);
    import regprot_pkg::*;

    localparam int FW = $clog2(FAST_CYC + 1);
    localparam int SW = $clog2(SLOW_CYC + 1);
    localparam int WW = $clog2(WINDOW_CYC + 1);
    localparam logic [FW-1:0] FAST_MAX = FW'(FAST_CYC - 1);
    localparam logic [SW-1:0] SLOW_MAX = SW'(SLOW_CYC - 1);
    localparam logic [WW-1:0] WIN_MAX = WW'(WINDOW_CYC - 1);

    // Two-flop synchronisers for every pin-level input
    localparam int NS = 3 + 5 + 2 * CORES + 3 * CORES;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    wire [NS-1:0] raw_in = {ext_reset_in_n, analog_supply_rail, sw_reset, temp_warn_low, temp_warn_high,
        temp_shutdown, 2'b00, core_enable_pin, core_enable_reg, core_detect};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire [3*CORES-1:0] det_s = sync2_reg[3*CORES-1:0];
    wire [CORES-1:0] en_reg_s = sync2_reg[4*CORES-1:3*CORES];
    wire [CORES-1:0] en_pin_s = sync2_reg[5*CORES-1:4*CORES]; // [R19]
    wire tsd_s = sync2_reg[5*CORES+2];
    wire twh_s = sync2_reg[5*CORES+3];
    wire twl_s = sync2_reg[5*CORES+4];
    wire swr_s = sync2_reg[5*CORES+5];
    wire supply_ok = sync2_reg[5*CORES+6]; // [R18] acts without debounce
    wire ext_reset_in_n_s = sync2_reg[5*CORES+7];
    wire twarn_raw = thermal_warning_threshold_sel ? twh_s : twl_s; // [R9]

    // Debounced temperature levels, 20us both edges
    logic tw_deb;
    logic tsd_deb;
    logic [FW-1:0] tw_cnt_reg;
    logic [FW-1:0] tsd_cnt_reg;
    logic tw_deb_reg;
    logic tsd_deb_reg;
    assign tw_deb = tw_deb_reg;
    assign tsd_deb = tsd_deb_reg;

    // Counter restarts whenever the input agrees with the debounced level, so each window is exact to one clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tw_cnt_reg <= '0;
            tsd_cnt_reg <= '0;
            tw_deb_reg <= 1'b0;
            tsd_deb_reg <= 1'b0;
        end
        else
        begin
            tw_cnt_reg <= (twarn_raw == tw_deb_reg || tw_cnt_reg == FAST_MAX) ? '0 : tw_cnt_reg + 1'b1; // [R17]
            tsd_cnt_reg <= (tsd_s == tsd_deb_reg || tsd_cnt_reg == FAST_MAX) ? '0 : tsd_cnt_reg + 1'b1;
            if (twarn_raw != tw_deb_reg && tw_cnt_reg == FAST_MAX)
                tw_deb_reg <= twarn_raw; // [R18]
            if (tsd_s != tsd_deb_reg && tsd_cnt_reg == FAST_MAX)
                tsd_deb_reg <= tsd_s; // [R18]
        end
    end

    // Device state: shutdown on undervoltage, reset pin or software reset
    dev_state_t state_reg;
    dev_state_t state_next;
    wire go_down = !supply_ok || !ext_reset_in_n_s || swr_s; // [R14]
    logic [CORES-1:0] run_reg;
    wire tsd_block = tsd_deb || thermal_shutdown_flag; // [R13]

    always_comb
    begin
        case (state_reg)
            ST_SHUTDOWN: state_next = go_down ? ST_SHUTDOWN : ST_STANDBY; // [R14]
            ST_STANDBY: state_next = go_down ? ST_SHUTDOWN : (|run_reg ? ST_ACTIVE : ST_STANDBY);
            ST_ACTIVE: state_next = go_down ? ST_SHUTDOWN : ((|run_reg && !tsd_deb) ? ST_ACTIVE : ST_STANDBY); // [R11]
            default: state_next = ST_SHUTDOWN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= ST_SHUTDOWN;
        else
            state_reg <= state_next;
    end

    // Cores may only start outside shutdown and with no reset source active
    wire in_shutdown = (state_reg == ST_SHUTDOWN);
    wire powered = !in_shutdown && !go_down;
    assign device_state = state_reg;

    // Top-level flags; hardware set beats host clear
    wire rst_set = in_shutdown && !go_down; // [R15]
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            thermal_warning_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            reset_flag <= 1'b0;
        end
        else if (in_shutdown)
        begin
            // Registers return to defaults while down; only the reset flag survives
            thermal_warning_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            reset_flag <= reset_flag | rst_set; // [R15]
        end
        else
        begin
            thermal_warning_flag <= tw_deb || (thermal_warning_flag && !thermal_warning_clear); // [R9] [R10]
            thermal_shutdown_flag <= tsd_deb || (thermal_shutdown_flag && !thermal_shutdown_clear); // [R11] [R12]
            reset_flag <= reset_flag && !reset_flag_clear; // [R16]
        end
    end
    assign thermal_warning_state = tw_deb; // [R10]
    assign thermal_shutdown_state = tsd_deb; // [R12]

    // Per-core protection and flags
    logic [CORES-1:0] pend;
    genvar g;
    generate
        for (g = 0; g < CORES; g++)
        begin : gen_core
            logic [FW-1:0] il_cnt_reg;
            logic [FW-1:0] pg_cnt_reg;
            logic [SW-1:0] ol_cnt_reg;
            logic [WW-1:0] win_cnt_reg;
            logic il_reg;
            logic pg_reg;
            logic ol_reg;
            logic starting_reg;
            logic [ILIM_W-1:0] ilim_reg;
            wire il_raw = det_s[3*g+2];
            wire pg_raw = det_s[3*g+1];
            wire low_raw = det_s[3*g];
            wire want = enable_pin_ctrl[g] ? en_pin_s[g] : en_reg_s[g];
            wire win_end = starting_reg && win_cnt_reg == WIN_MAX;
            wire short_trip = win_end && low_raw; // [R4]
            // Overload watch is armed only once the start window has closed, so a low level
            // left over from a slow start cannot trip a core that has since recovered
            wire ol_arm = run_reg[g] && !starting_reg;
            wire over_trip = ol_arm && ol_reg; // [R5]
            wire trip = short_trip || over_trip;
            // A pending short flag holds the core off until the host clears it
            wire sc_flag = core_flags[g].short_circuit;
            wire can_start = want && powered && !tsd_block && !sc_flag; // [R7] [R13]

            always_ff @(posedge clk)
            begin
                if (!rst_n || in_shutdown)
                begin
                    il_cnt_reg <= '0;
                    pg_cnt_reg <= '0;
                    ol_cnt_reg <= '0;
                    win_cnt_reg <= '0;
                    il_reg <= 1'b0;
                    pg_reg <= 1'b0;
                    ol_reg <= 1'b0;
                    starting_reg <= 1'b0;
                    run_reg[g] <= 1'b0;
                    ilim_reg <= ILIM_RESET;
                    core_flags[g] <= '0;
                end
                else
                begin
                    ilim_reg <= peak_current_limit_sel[ILIM_W*g +: ILIM_W]; // [R3]
                    il_cnt_reg <= (il_raw == il_reg || il_cnt_reg == FAST_MAX) ? '0 : il_cnt_reg + 1'b1; // [R17]
                    pg_cnt_reg <= (pg_raw == pg_reg || pg_cnt_reg == FAST_MAX) ? '0 : pg_cnt_reg + 1'b1;
                    // Overload counter idles while the watch is not armed
                    ol_cnt_reg <= (!ol_arm || low_raw == ol_reg || ol_cnt_reg == SLOW_MAX) ? '0 : ol_cnt_reg + 1'b1;
                    if (il_raw != il_reg && il_cnt_reg == FAST_MAX)
                        il_reg <= il_raw; // [R18]
                    if (pg_raw != pg_reg && pg_cnt_reg == FAST_MAX)
                        pg_reg <= pg_raw; // [R18]
                    if (!ol_arm)
                        ol_reg <= 1'b0;
                    else if (low_raw != ol_reg && ol_cnt_reg == SLOW_MAX)
                        ol_reg <= low_raw; // [R18]
                    // Start-up window counts from enable
                    win_cnt_reg <= starting_reg ? win_cnt_reg + 1'b1 : '0;
                    if (trip || !want || tsd_deb || !powered)
                    begin
                        run_reg[g] <= 1'b0; // [R6] [R11]
                        starting_reg <= 1'b0;
                    end
                    else if (!run_reg[g] && can_start)
                    begin
                        run_reg[g] <= 1'b1;
                        starting_reg <= 1'b1;
                    end
                    else if (win_end)
                        starting_reg <= 1'b0;
                    core_flags[g].current_limit <= (il_raw != il_reg && il_cnt_reg == FAST_MAX && il_raw)
                        || (core_flags[g].current_limit && !core_flag_clear[g].current_limit); // [R1]
                    core_flags[g].power_good <= (pg_raw != pg_reg && pg_cnt_reg == FAST_MAX && pg_raw)
                        || (core_flags[g].power_good && !core_flag_clear[g].power_good); // [R20]
                    core_flags[g].short_circuit <= trip
                        || (core_flags[g].short_circuit && !core_flag_clear[g].short_circuit); // [R6] [R7]
                end
            end

            // Running status and switch/discharge pin drives follow the running bit
            assign core_current_limit_state[g] = il_reg; // [R2]
            assign core_power_good_state[g] = pg_reg;
            assign core_ilim_setting[ILIM_W*g +: ILIM_W] = ilim_reg; // [R3]
            assign core_running_state[g] = run_reg[g]; // [R6]
            assign core_switch_enable[g] = run_reg[g]; // [R8]
            assign core_discharge_on[g] = !run_reg[g] && discharge_pulldown_enable[g]; // [R8] [R14]
            assign core_summary_flag[g] = |core_flags[g]; // [R6]
            assign pend[g] = (core_flags[g].current_limit && !core_current_limit_mask[g])
                || (core_flags[g].power_good && !core_power_good_mask[g])
                || core_flags[g].short_circuit; // [R20] [R22]
        end
    endgenerate

    // Interrupt pin: low while any unmasked flag is pending
    wire any_pend = |pend || (thermal_warning_flag && !thermal_warning_mask) || thermal_shutdown_flag
        || (reset_flag && !reset_flag_mask); // [R22]
    assign irq_out_n = !any_pend; // [R21]
endmodule

// ### logic/regprot_pkg.sv
package regprot_pkg;
    localparam int NUM_CORES = 4;
    localparam int CLK_HZ = 40_000_000;
    // Debounce and protection times, in microseconds and in clock cycles
    localparam int FAST_DEBOUNCE_US = 20;
    localparam int SLOW_DEBOUNCE_US = 1000;
    localparam int SHORT_WINDOW_US = 1000;
    localparam int FAST_DEBOUNCE_CYC = FAST_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int SLOW_DEBOUNCE_CYC = SLOW_DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int SHORT_WINDOW_CYC = SHORT_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int ILIM_W = 3;
    localparam logic [ILIM_W-1:0] ILIM_RESET = 3'h0;

    // Analog detector outputs for one core
    typedef struct packed {
        logic current_limit;
        logic power_good;
        logic below_short;
    } core_detect_t;

    // Per-core flags
    typedef struct packed {
        logic current_limit;
        logic short_circuit;
        logic power_good;
    } core_flags_t;

    typedef enum logic [1:0] {
        ST_SHUTDOWN = 2'b00,
        ST_STANDBY = 2'b01,
        ST_ACTIVE = 2'b10
    } dev_state_t;
endpackage

// ### tb/regprot_props.sv
`timescale 1ns/10ps
module regprot_props
    import regprot_pkg::*;
#(
    parameter int CORES = NUM_CORES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic analog_supply_rail,
    input wire logic [CORES*ILIM_W-1:0] peak_current_limit_sel,
    input wire logic [CORES-1:0] discharge_pulldown_enable,
    input wire logic [CORES-1:0] core_current_limit_mask,
    input wire logic [CORES-1:0] core_power_good_mask,
    input wire logic thermal_warning_mask,
    input wire logic reset_flag_mask,
    input wire logic thermal_warning_clear,
    input wire regprot_pkg::core_flags_t [CORES-1:0] core_flags,
    input wire logic [CORES-1:0] core_summary_flag,
    input wire logic [CORES-1:0] core_current_limit_state,
    input wire logic [CORES-1:0] core_power_good_state,
    input wire logic [CORES-1:0] core_running_state,
    input wire logic [CORES*ILIM_W-1:0] core_ilim_setting,
    input wire logic [CORES-1:0] core_discharge_on,
    input wire logic [CORES-1:0] core_switch_enable,
    input wire logic thermal_warning_flag,
    input wire logic thermal_warning_state,
    input wire logic thermal_shutdown_flag,
    input wire logic thermal_shutdown_state,
    input wire logic reset_flag,
    input wire regprot_pkg::dev_state_t device_state,
    input wire logic irq_out_n
);
    logic [CORES-1:0] cl_vec, sc_vec, pg_vec;
    logic pending;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Split the flag structs into per-kind vectors
    always_comb
    begin
        for (int n = 0; n < CORES; n++)
        begin
            cl_vec[n] = core_flags[n].current_limit;
            sc_vec[n] = core_flags[n].short_circuit;
            pg_vec[n] = core_flags[n].power_good;
        end
    end
    // Masked flags stay visible but must not pull the pin
    assign pending = |(cl_vec & ~core_current_limit_mask) | |(pg_vec & ~core_power_good_mask) | |sc_vec
        | (thermal_warning_flag & ~thermal_warning_mask) | thermal_shutdown_flag | (reset_flag & ~reset_flag_mask);
    irq_or_a: assert property (irq_out_n == !pending) else $error("irq pin differs from unmasked flags");
    summary_flag_a: assert property (core_summary_flag == (cl_vec | sc_vec | pg_vec))
        else $error("summary flag wrong");
    short_stops_a: assert property ((sc_vec & core_running_state) == '0) else $error("core runs with short");
    discharge_on_a: assert property (core_discharge_on == (~core_running_state & discharge_pulldown_enable))
        else $error("discharge wrong");
    ilim_flag_a: assert property (((cl_vec & ~$past(cl_vec)) & ~(core_current_limit_state
        | $past(core_current_limit_state))) == '0) else $error("current flag without state");
    ilim_sel_a: assert property ((device_state == ST_ACTIVE && $past(device_state) == ST_ACTIVE)
        |-> core_ilim_setting == $past(peak_current_limit_sel)) else $error("limit setting not taken");
    warn_clear_a: assert property ((thermal_warning_clear && thermal_warning_flag && !thermal_warning_state)
        |=> (!thermal_warning_flag || thermal_warning_state)) else $error("warning clear lost");
    tsd_hold_a: assert property ((thermal_shutdown_state && device_state != ST_SHUTDOWN)
        |=> (thermal_shutdown_flag || device_state == ST_SHUTDOWN)) else $error("shutdown flag cleared hot");
    tsd_off_a: assert property ((thermal_shutdown_flag && $past(thermal_shutdown_flag))
        |-> core_running_state == '0) else $error("core runs in thermal shutdown");
    uvlo_down_a: assert property (!analog_supply_rail
        |-> ##[1:4] (device_state == ST_SHUTDOWN && core_running_state == '0)) else $error("no shutdown");
    reset_seen_a: assert property (($past(device_state) == ST_SHUTDOWN && device_state != ST_SHUTDOWN)
        |-> ##[0:2] reset_flag) else $error("reset flag missing");
    switch_off_a: assert property ((core_switch_enable & (sc_vec | ~core_running_state)) == '0)
        else $error("switches driven on a stopped core");
    pg_state_a: assert property (((pg_vec & ~$past(pg_vec)) & ~core_power_good_state) == '0)
        else $error("power-good flag without state");
endmodule
bind regulator_protection_interrupts regprot_props #(.CORES(CORES)) u_regprot_props (.clk, .rst_n,
    .analog_supply_rail, .peak_current_limit_sel, .discharge_pulldown_enable, .core_current_limit_mask,
    .core_power_good_mask, .thermal_warning_mask, .reset_flag_mask, .thermal_warning_clear, .core_flags,
    .core_summary_flag, .core_current_limit_state, .core_power_good_state, .core_running_state,
    .core_ilim_setting, .core_discharge_on, .core_switch_enable, .thermal_warning_flag, .thermal_warning_state,
    .thermal_shutdown_flag, .thermal_shutdown_state, .reset_flag, .device_state, .irq_out_n);

// ### tb/host_model.sv
`timescale 1ns/10ps
module host_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic service,
    input wire logic irq_out_n,
    input wire logic reset_flag,
    output logic reset_flag_clear
);
    // Write-one clear of the reset flag; one cycle only so it is not repeated
    always_ff @(posedge clk)
    begin
        reset_flag_clear <= rst_n && service && !irq_out_n && reset_flag && !reset_flag_clear;
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench
    import regprot_pkg::*;
();
    typedef struct packed {logic [3:0] cl, sc, pg, run; logic tw, ts, rf, irq_n;} snap_t;
    localparam int FC = 8;
    logic clk, rst_n, ext_reset_in_n, analog_supply_rail, sw_reset, service, temp_warn_low, temp_warn_high;
    logic temp_shutdown, thermal_warning_threshold_sel, thermal_warning_mask, reset_flag_mask;
    logic thermal_warning_clear, thermal_shutdown_clear, reset_flag_clear, thermal_warning_flag;
    logic thermal_warning_state, thermal_shutdown_flag, thermal_shutdown_state, reset_flag, irq_out_n;
    logic [3:0] core_enable_pin, core_enable_reg, enable_pin_ctrl, discharge_pulldown_enable;
    logic [3:0] core_current_limit_mask, core_power_good_mask, core_summary_flag, core_current_limit_state;
    logic [3:0] core_power_good_state, core_running_state, core_switch_enable, core_discharge_on;
    logic [11:0] peak_current_limit_sel, core_ilim_setting;
    core_detect_t [3:0] core_detect;
    core_flags_t [3:0] core_flag_clear, core_flags;
    dev_state_t device_state;
    integer seed = 32'h8147, fail_count = 0, checks = 0, i, j, k;
    snap_t e;
    snap_t exp_q[$];
    event chk_ev;
    regulator_protection_interrupts #(.FAST_CYC(FC), .SLOW_CYC(20), .WINDOW_CYC(20)) u_regulator_protection_interrupts
        (.clk, .rst_n, .ext_reset_in_n, .analog_supply_rail, .sw_reset, .core_enable_pin, .core_enable_reg,
        .enable_pin_ctrl, .core_detect, .temp_warn_low, .temp_warn_high, .temp_shutdown,
        .thermal_warning_threshold_sel, .peak_current_limit_sel, .discharge_pulldown_enable, .core_current_limit_mask,
        .core_power_good_mask, .thermal_warning_mask, .reset_flag_mask, .core_flag_clear, .thermal_warning_clear,
        .thermal_shutdown_clear, .reset_flag_clear, .core_flags, .core_summary_flag, .core_current_limit_state,
        .core_power_good_state, .core_running_state, .core_ilim_setting, .core_switch_enable, .core_discharge_on,
        .thermal_warning_flag, .thermal_warning_state, .thermal_shutdown_flag, .thermal_shutdown_state, .reset_flag,
        .device_state, .irq_out_n);
    host_model u_host_model (.clk, .rst_n, .service, .irq_out_n, .reset_flag, .reset_flag_clear);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Inputs move 2 ns after the edge, away from sampling
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task note_exp(input snap_t s);
        exp_q.push_back(s);
        -> chk_ev;
        #0; // Yield so the monitor samples before the caller moves any input
    endtask
    task cmp_snap(input snap_t x, input snap_t g);
        checks++;
        if (g !== x)
        begin
            fail_count++;
            $display("ERROR %0t flags exp %h got %h", $time, x, g);
        end
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Monitor: outputs have settled 2 ns after the edge; sample them before new stimulus lands
    initial
    begin
        snap_t g;
        forever
        begin
            @chk_ev;
            for (int n = 0; n < 4; n++)
                {g.cl[n], g.sc[n], g.pg[n]} = core_flags[n];
            g.run = core_running_state;
            {g.tw, g.ts, g.rf, g.irq_n} = {thermal_warning_flag, thermal_shutdown_flag, reset_flag, irq_out_n};
            cmp_snap(exp_q.pop_front(), g);
        end
    end
    // Bounded run; many times the expected length
    initial
    begin
        #200_000;
        fail_count++;
        $display("ERROR %0t timeout", $time);
        report_and_stop();
    end
    initial
    begin
        {rst_n, sw_reset, service, core_enable_pin, core_enable_reg, enable_pin_ctrl, core_detect, temp_warn_low} = '0;
        {temp_warn_high, temp_shutdown, thermal_warning_threshold_sel, core_current_limit_mask} = '0;
        {core_power_good_mask, thermal_warning_mask, reset_flag_mask, core_flag_clear} = '0;
        {thermal_warning_clear, thermal_shutdown_clear} = '0;
        {ext_reset_in_n, analog_supply_rail, discharge_pulldown_enable} = '1;
        peak_current_limit_sel = 12'($random(seed));
        step(10);
        rst_n = 1'b1;
        step(6);
        e = '0;
        e.rf = 1'b1;
        note_exp(e);
        service = 1'b1;
        step(3);
        e = '0;
        e.irq_n = 1'b1;
        note_exp(e);
        $display("power-up reset flag done");
        i = $unsigned($random(seed)) % 4;
        core_detect[i].current_limit = 1'b1;
        step(FC + 5);
        e.cl[i] = 1'b1;
        e.irq_n = 1'b0;
        note_exp(e);
        core_current_limit_mask[i] = 1'b1;
        step(2);
        e.irq_n = 1'b1;
        note_exp(e);
        core_current_limit_mask[i] = 1'b0;
        core_detect[i].current_limit = 1'b0;
        step(FC + 5);
        core_flag_clear[i].current_limit = 1'b1;
        step(1);
        core_flag_clear = '0;
        step(1);
        e = '0;
        e.irq_n = 1'b1;
        note_exp(e);
        $display("current limit done");
        core_power_good_mask = 4'hf;
        core_detect = 12'h492;
        step(FC + 6);
        e.pg = 4'hf;
        note_exp(e);
        core_power_good_mask = 4'h0;
        step(2);
        e.irq_n = 1'b0;
        note_exp(e);
        core_detect = '0;
        step(FC + 6);
        core_flag_clear = 12'h249;
        step(1);
        core_flag_clear = '0;
        step(1);
        e = '0;
        e.irq_n = 1'b1;
        note_exp(e);
        $display("power good done");
        for (k = 0; k < 2; k++)
        begin
            thermal_warning_threshold_sel = k[0];
            temp_warn_low = 1'b1;
            step(FC + 6);
            e.tw = (k == 0);
            e.irq_n = (k != 0);
            note_exp(e);
            temp_warn_high = 1'b1;
            step(FC + 6);
            e.tw = 1'b1;
            e.irq_n = 1'b0;
            note_exp(e);
            thermal_warning_clear = 1'b1;
            step(1);
            thermal_warning_clear = 1'b0;
            step(1);
            note_exp(e);
            {temp_warn_low, temp_warn_high} = '0;
            step(FC + 6);
            thermal_warning_clear = 1'b1;
            step(1);
            thermal_warning_clear = 1'b0;
            step(1);
            e = '0;
            e.irq_n = 1'b1;
            note_exp(e);
        end
        $display("thermal warning done");
        j = $unsigned($random(seed)) % 4;
        core_enable_reg[j] = 1'b1;
        core_detect[j].below_short = 1'b1;
        step(26);
        e.sc[j] = 1'b1;
        e.irq_n = 1'b0;
        note_exp(e);
        core_detect[j].below_short = 1'b0;
        core_flag_clear[j].short_circuit = 1'b1;
        step(1);
        core_flag_clear = '0;
        step(3);
        e = '0;
        e.run[j] = 1'b1;
        e.irq_n = 1'b1;
        note_exp(e);
        peak_current_limit_sel = 12'($random(seed));
        step(24);
        core_detect[j].below_short = 1'b1;
        step(26);
        e.run[j] = 1'b0;
        e.sc[j] = 1'b1;
        e.irq_n = 1'b0;
        note_exp(e);
        {core_enable_reg[j], core_detect[j].below_short} = 2'b00;
        core_flag_clear[j].short_circuit = 1'b1;
        step(1);
        core_flag_clear = '0;
        step(3);
        e = '0;
        e.irq_n = 1'b1;
        note_exp(e);
        $display("short and overload done");
        {enable_pin_ctrl, core_enable_pin} = '1;
        step(8);
        e.run = 4'hf;
        note_exp(e);
        temp_shutdown = 1'b1;
        step(FC + 6);
        e = '0;
        e.ts = 1'b1;
        note_exp(e);
        thermal_shutdown_clear = 1'b1;
        step(1);
        thermal_shutdown_clear = 1'b0;
        step(1);
        note_exp(e);
        temp_shutdown = 1'b0;
        step(FC + 6);
        note_exp(e);
        core_enable_pin = '0;
        thermal_shutdown_clear = 1'b1;
        step(1);
        thermal_shutdown_clear = 1'b0;
        step(3);
        e = '0;
        e.irq_n = 1'b1;
        note_exp(e);
        $display("thermal shutdown done");
        // Supply loss, reset pin and software reset each pass through shutdown
        for (k = 0; k < 3; k++)
        begin
            service = 1'b0;
            reset_flag_mask = (k == 2);
            {analog_supply_rail, ext_reset_in_n, sw_reset} = {k != 0, k != 1, k == 2};
            step(5);
            note_exp(e);
            {analog_supply_rail, ext_reset_in_n, sw_reset} = 3'b110;
            step(8);
            {e.rf, e.irq_n} = {1'b1, k == 2};
            note_exp(e);
            service = 1'b1;
            step(3);
            {e.rf, e.irq_n} = {k == 2, 1'b1};
            note_exp(e);
        end
        $display("reset sources done");
        step(2);
        report_and_stop();
    end
endmodule
